// file: amc_mode_clock_monitor.sv
// Operating-mode controller and serial-audio clock supervisor
//
// Overview of operation
// - Timing comes from the bit clock; ratios 16..512, doubled rates refuse 384+.
// - A right sample-rate select and valid ratio need no other clock setup.
// - Bad bit-clock rate or ratio ramps playback volume down.
// - With halt disable low, clock error leads to halt after the halt delay.
// - Auto power-cycle follows valid clocks; software keeps halt disable low.
// - Echo enable sends the processed sample in the chosen transmit slot.
// - Shutdown pin low means hardware shutdown, registers lost, bus disabled.
// - Shutdown pin low forces hardware shutdown after the selected timeout.
// - Graceful: ramp down, stop switching, power down, then hardware shutdown.
// - Forced behaviour select skips the graceful ramp-down.
// - Shutdown release samples the address strap, then software shutdown.
// - Soft reset restores register defaults and clears itself.
// - Mode 010 is software shutdown after ramp; leaving it ramps back up.
// - Mode 001 ramps to mute while the output keeps switching.
// - Mode 000 is active: switching, audio and sensing.
// - Diagnostic generator runs on internal oscillator when its clock select low.
// - Diagnostic DC level is output; software zeroes the DC blocker first.
// - Noise gate stops output switching while signal is below threshold; analog stays powered.
// - Clock faults drop to software shutdown; volume ramps back when clear.
// - Unmasked clock error drives interrupt low; fault latched in status.
`timescale 1ns/1ps
`default_nettype none
module amc_mode_clock_monitor
  import amc_pkg::*;
#(
  parameter int unsigned HALT_UNIT = HALT_UNIT_CYC,
  parameter int unsigned SDZ_UNIT = SDZ_UNIT_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic serialBitClock,
  input wire logic frameSync,
  input wire logic shutdownNPin,
  input wire logic addrStrapPin,
  input wire amc_cfg_t cfg,
  input wire logic softResetWrite,
  input wire logic clearLatched,
  input wire logic signalBelowThreshold,
  input wire logic [31:0] playbackSample,
  output amc_pwr_t pwr,
  output logic [7:0] volume,
  output logic clockError,
  output logic clockErrorLatched,
  output logic softResetBit,
  output logic registerDefaults,
  output logic busAddress,
  output logic interruptNOut,
  output logic interruptNOe,
  output logic echoTxBit,
  output logic echoTxOe,
  output logic diagOscEn,
  output logic [31:0] diagSample
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and state

  typedef enum logic [3:0] {
    stHwShutdown, stSwShutdown, stRun, stRampDown, stHalt,
    stSdzRamp, stSdzStop, stSdzPower
  } amc_state_t;

  typedef struct packed {
    amc_state_t state;
    logic prevBclk;
    logic prevFs;
    logic frameSeen;
    logic [15:0] frameCnt;
    logic [9:0] bitCnt;
    logic clockErr;
    logic errLatched;
    logic irqOe;
    logic [23:0] haltCnt;
    logic [23:0] sdzCnt;
    logic strapAddr;
    logic resetPulse;
    logic [31:0] echoShift;
    logic echoBit;
    logic echoOe;
    logic [31:0] diagOut;
    amc_pwr_t pwr;
  } amc_core_t;

  amc_core_t st_reg, st_next;

  logic [3:0] pinSync;
  logic bclkS, fsS, sdzS, strapS;
  logic [7:0] rampTarget;
  logic [7:0] rampVol;
  logic rampDone;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and volume ramp

  amc_sync #(.W(4)) u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .asyncIn({serialBitClock, frameSync, shutdownNPin, addrStrapPin}),
    .syncOut(pinSync)
  );

  assign {bclkS, fsS, sdzS, strapS} = pinSync;

  amc_vol_ramp u_ramp (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .target(rampTarget),
    .volume(rampVol),
    .atTarget(rampDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame window for the selected rate

  logic [15:0] frameMin, frameMax;
  logic rateKnown, hiRate;

  // Expected frame length with tolerance
  always_comb begin
    int unsigned nom;
    nom = FRAME_CYC_48K;
    rateKnown = 1'b1;
    hiRate = 1'b0;
    case (cfg.sampleRateSel)
      RATE_48K: nom = FRAME_CYC_48K;
      RATE_44K: nom = FRAME_CYC_44K;
      RATE_96K: begin
        nom = FRAME_CYC_96K;
        hiRate = 1'b1;
      end
      RATE_88K: begin
        nom = FRAME_CYC_88K;
        hiRate = 1'b1;
      end
      default: rateKnown = 1'b0;
    endcase
    frameMin = 16'(nom * (100 - FRAME_TOL_PCT) / 100);
    frameMax = 16'(nom * (100 + FRAME_TOL_PCT) / 100);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic bclkRise, fsRise, playReq, diagInternal, effErr;
  logic slotIn;
  logic [9:0] bitPos;
  logic [31:0] shiftSrc;
  logic [23:0] haltLimit, sdzLimit;

  always_comb begin
    st_next = st_reg;
    bclkRise = bclkS && !st_reg.prevBclk;
    fsRise = fsS && !st_reg.prevFs;
    st_next.prevBclk = bclkS;
    st_next.prevFs = fsS;
    st_next.resetPulse = 1'b0;
    haltLimit = 24'(HALT_UNIT * ({29'h0, cfg.haltTimerSel} + 32'h1));
    sdzLimit = 24'(SDZ_UNIT * ({30'h0, cfg.shutdownTimeoutSel} + 32'h1));

    // Frame length and bit count per frame
    if (st_reg.frameCnt < STALL_CYC) begin
      st_next.frameCnt = st_reg.frameCnt + 16'h0001;
    end
    bitPos = fsRise ? 10'h000 : st_reg.bitCnt;
    shiftSrc = fsRise ? playbackSample : st_reg.echoShift;
    if (fsRise) begin
      // Rate and ratio judged once per frame
      // The partial frame seen after reset is not judged
      st_next.clockErr = st_reg.frameSeen && !(rateKnown &&
        ratio_ok(st_reg.bitCnt, hiRate) &&
        st_reg.frameCnt >= frameMin && st_reg.frameCnt <= frameMax);
      st_next.frameSeen = 1'b1;
      st_next.frameCnt = '0;
      st_next.bitCnt = bclkRise ? 10'h001 : 10'h000;
      st_next.echoShift = playbackSample;
    end else if (bclkRise && st_reg.bitCnt != 10'h3ff) begin
      st_next.bitCnt = st_reg.bitCnt + 10'h001;
    end
    // Stopped bit clock or frame sync
    if (st_reg.frameCnt >= STALL_CYC) begin
      st_next.clockErr = 1'b1;
    end

    // Echo loopback in the selected slot
    slotIn = (cfg.echoSlotLen ? (bitPos >> SLOT_SHIFT_32) :
      (bitPos >> SLOT_SHIFT_16)) == {4'h0, cfg.echoSlot};
    if (bclkRise) begin
      st_next.echoOe = cfg.echoTxEn && slotIn && !st_reg.clockErr;
      if (slotIn) begin
        st_next.echoBit = shiftSrc[31];
        st_next.echoShift = {shiftSrc[30:0], 1'b0};
      end
    end

    // Sticky fault, new event wins over clear
    st_next.errLatched = (st_reg.errLatched && !clearLatched) ||
      st_next.clockErr;
    st_next.irqOe = st_next.clockErr && !cfg.clockErrorMask;

    // Diagnostic generator output
    diagInternal = cfg.diagEnable && !cfg.diagClockSel;
    st_next.diagOut = (cfg.diagEnable && cfg.diagPatternSel == DIAG_PAT_DC) ?
      cfg.diagDcLevel : 32'h0000_0000;
    effErr = st_reg.clockErr && !diagInternal;

    playReq = cfg.modeSel == MODE_ACTIVE || cfg.modeSel == MODE_MUTE;

    // Soft reset pulse self clears next cycle
    if (softResetWrite) begin
      st_next.resetPulse = 1'b1;
      st_next.errLatched = st_next.clockErr;
      st_next.haltCnt = '0;
    end

    // Mode sequencing
    unique case (st_reg.state)
      stHwShutdown: begin
        // Strap caught on release, then software shutdown
        if (sdzS) begin
          st_next.strapAddr = strapS;
          st_next.state = stSwShutdown;
        end
      end
      stSwShutdown: begin
        if (playReq && !effErr) begin
          st_next.haltCnt = '0;
          st_next.state = stRun;
        end else if (effErr && !cfg.haltDisable) begin
          // Halt after the selected delay
          if (st_reg.haltCnt >= haltLimit - 24'h000001) begin
            st_next.state = stHalt;
          end else begin
            st_next.haltCnt = st_reg.haltCnt + 24'h000001;
          end
        end else begin
          st_next.haltCnt = '0;
        end
      end
      stRun: begin
        if (!playReq || effErr) begin
          st_next.state = stRampDown;
        end
      end
      stRampDown: begin
        if (playReq && !effErr) begin
          st_next.state = stRun;
        end else if (rampVol == 8'h00) begin
          st_next.state = stSwShutdown;
        end
      end
      stHalt: begin
        // Leave halt when clocks return or software steps
        if (cfg.haltDisable || (cfg.autoPowerCycleEn && !effErr) ||
            (!cfg.autoPowerCycleEn && cfg.modeSel == MODE_SW_SHUTDOWN)) begin
          st_next.haltCnt = '0;
          st_next.state = stSwShutdown;
        end
      end
      stSdzRamp: begin
        if (rampVol == 8'h00) begin
          st_next.state = stSdzStop;
        end
      end
      stSdzStop: st_next.state = stSdzPower;
      stSdzPower: st_next.state = stHwShutdown;
    endcase

    // Shutdown pin handling
    if (!sdzS) begin
      if (st_reg.state == stSdzRamp || st_reg.state == stSdzStop ||
          st_reg.state == stSdzPower) begin
        st_next.sdzCnt = st_reg.sdzCnt + 24'h000001;
        if (st_reg.sdzCnt >= sdzLimit - 24'h000001) begin
          st_next.state = stHwShutdown;
        end
      end else if (st_reg.state != stHwShutdown) begin
        st_next.sdzCnt = '0;
        if (cfg.shutdownBehaviourSel == SDZ_FORCED) begin
          st_next.state = stHwShutdown;
        end else if (st_reg.state == stRun || st_reg.state == stRampDown) begin
          st_next.state = stSdzRamp;
        end else begin
          st_next.state = stSdzStop;
        end
      end
    end

    // Power flags follow the next state
    st_next.pwr = '0;
    st_next.pwr.busEnable = 1'b1;
    st_next.pwr.digitalPowered = 1'b1;
    unique case (st_next.state)
      stHwShutdown: begin
        st_next.pwr.hwShutdown = 1'b1;
        st_next.pwr.busEnable = 1'b0;
        st_next.pwr.digitalPowered = 1'b0;
      end
      stSwShutdown: ;
      stRun: begin
        // Noise gate idles the output stage
        st_next.pwr.outputSwitching = !(cfg.noiseGateEn &&
          signalBelowThreshold);
        st_next.pwr.analogPowered = 1'b1;
        st_next.pwr.senseEnable = cfg.modeSel == MODE_ACTIVE;
      end
      stRampDown, stSdzRamp: begin
        st_next.pwr.outputSwitching = 1'b1;
        st_next.pwr.analogPowered = 1'b1;
      end
      stHalt: begin
        st_next.pwr.haltActive = 1'b1;
        st_next.pwr.digitalPowered = 1'b0;
      end
      stSdzStop: st_next.pwr.analogPowered = 1'b1;
      stSdzPower: st_next.pwr.digitalPowered = 1'b0;
    endcase
  end

  // Ramp target: programmed level in active, zero in mute and elsewhere
  always_comb begin
    rampTarget = 8'h00;
    if (st_reg.state == stRun && cfg.modeSel == MODE_ACTIVE) begin
      rampTarget = cfg.volumeLevel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pwr = st_reg.pwr;
  assign volume = rampVol;
  assign clockError = st_reg.clockErr;
  assign clockErrorLatched = st_reg.errLatched;
  assign softResetBit = st_reg.resetPulse;
  assign registerDefaults = st_reg.resetPulse || st_reg.pwr.hwShutdown;
  assign busAddress = st_reg.strapAddr;
  assign interruptNOut = 1'b0; // Open drain, only pulls low
  assign interruptNOe = st_reg.irqOe;
  assign echoTxBit = st_reg.echoBit;
  assign echoTxOe = st_reg.echoOe;
  assign diagOscEn = diagInternal;
  assign diagSample = st_reg.diagOut;

endmodule
`default_nettype wire

// file: amc_pkg.sv
// Shared constants, types and helpers for the amplifier mode and clock monitor
package amc_pkg;

  // System clock
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_NS = 25;

  // Sample-rate select codes
  localparam logic [2:0] RATE_48K = 3'h0;
  localparam logic [2:0] RATE_44K = 3'h1;
  localparam logic [2:0] RATE_96K = 3'h2;
  localparam logic [2:0] RATE_88K = 3'h3;

  // Frame rates in Hz and nominal frame lengths in system cycles
  localparam int unsigned FS_48K_HZ = 48000;
  localparam int unsigned FS_44K_HZ = 44100;
  localparam int unsigned FS_96K_HZ = 96000;
  localparam int unsigned FS_88K_HZ = 88200;
  localparam int unsigned FRAME_CYC_48K = CLK_HZ / FS_48K_HZ;
  localparam int unsigned FRAME_CYC_44K = CLK_HZ / FS_44K_HZ;
  localparam int unsigned FRAME_CYC_96K = CLK_HZ / FS_96K_HZ;
  localparam int unsigned FRAME_CYC_88K = CLK_HZ / FS_88K_HZ;
  localparam int unsigned FRAME_TOL_PCT = 5;

  // Frame sync missing for this long counts as a stopped clock
  localparam int unsigned STALL_FRAMES = 2;
  localparam logic [15:0] STALL_CYC = 16'(STALL_FRAMES * FRAME_CYC_44K);

  // Ratios at or above this are refused at the doubled rates
  localparam logic [9:0] RATIO_HI_RATE_LIMIT = 10'h180;

  // Mode field codes
  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_MUTE = 3'h1;
  localparam logic [2:0] MODE_SW_SHUTDOWN = 3'h2;

  // Shutdown behaviour code for forced shutdown
  localparam logic [1:0] SDZ_FORCED = 2'h1;

  // Timer units: halt and shutdown delays are (select + 1) units
  localparam int unsigned HALT_UNIT_US = 1000;
  localparam int unsigned HALT_UNIT_CYC = HALT_UNIT_US * (CLK_HZ / 1000000);
  localparam int unsigned SDZ_UNIT_US = 1000;
  localparam int unsigned SDZ_UNIT_CYC = SDZ_UNIT_US * (CLK_HZ / 1000000);

  // Volume ramp: one step per interval
  localparam int unsigned RAMP_STEP_NS = 1000;
  localparam int unsigned RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;

  // Echo slot length codes: low = 16 bits, high = 32 bits
  localparam int unsigned SLOT_SHIFT_16 = 4;
  localparam int unsigned SLOT_SHIFT_32 = 5;

  // Diagnostic pattern code for the DC level
  localparam logic [4:0] DIAG_PAT_DC = 5'h01;

  // Configuration from the control registers
  typedef struct packed {
    logic [2:0] modeSel;
    logic [2:0] sampleRateSel;
    logic haltDisable;
    logic [2:0] haltTimerSel;
    logic autoPowerCycleEn;
    logic [1:0] shutdownTimeoutSel;
    logic [1:0] shutdownBehaviourSel;
    logic [7:0] volumeLevel;
    logic echoTxEn;
    logic echoSlotLen;
    logic [5:0] echoSlot;
    logic diagEnable;
    logic diagClockSel;
    logic [4:0] diagPatternSel;
    logic [31:0] diagDcLevel;
    logic [2:0] playbackDcBlockSel;
    logic noiseGateEn;
    logic clockErrorMask;
  } amc_cfg_t;

  // Power and status flags towards the rest of the chip
  typedef struct packed {
    logic outputSwitching;
    logic analogPowered;
    logic digitalPowered;
    logic haltActive;
    logic hwShutdown;
    logic busEnable;
    logic senseEnable;
  } amc_pwr_t;

  // Legal bit-clock to frame ratios for the chosen rate
  function automatic logic ratio_ok(input logic [9:0] r, input logic hiRate);
    logic inSet;
    inSet = 1'b0;
    case (r)
      10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h060, 10'h07d,
      10'h080, 10'h0c0, 10'h0fa, 10'h100, 10'h180, 10'h1f4,
      10'h200: inSet = 1'b1;
      default: inSet = 1'b0;
    endcase
    return inSet && !(hiRate && r >= RATIO_HI_RATE_LIMIT);
  endfunction

endpackage

// file: amc_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module amc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } amc_sync_state_t;

  amc_sync_state_t st_reg, st_next;

  // First stage feeds only the second
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = asyncIn;
    st_next.stage2 = st_reg.stage1;
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.stage2;

endmodule
`default_nettype wire

// file: amc_vol_ramp.sv
// Stepped volume ramp towards a target level
`timescale 1ns/1ps
`default_nettype none
module amc_vol_ramp
  import amc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] target,
  output logic [7:0] volume,
  output logic atTarget
);

  typedef struct packed {
    logic [7:0] vol;
    logic [15:0] stepCnt;
  } amc_ramp_state_t;

  amc_ramp_state_t st_reg, st_next;

  // One step up or down each interval until the target is reached
  always_comb begin
    st_next = st_reg;
    if (st_reg.vol == target) begin
      st_next.stepCnt = '0;
    end else if (st_reg.stepCnt >= 16'(RAMP_STEP_CYC - 1)) begin
      st_next.stepCnt = '0;
      if (st_reg.vol < target) begin
        st_next.vol = st_reg.vol + 8'h01;
      end else begin
        st_next.vol = st_reg.vol - 8'h01;
      end
    end else begin
      st_next.stepCnt = st_reg.stepCnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign volume = st_reg.vol;
  assign atTarget = (st_reg.vol == target);

endmodule
`default_nettype wire

// file: amc_mode_clock_monitor_sva.sv
// Assertion checker for the mode controller and clock monitor
`timescale 1ns/1ps
`default_nettype none
module amc_mode_clock_monitor_sva
  import amc_pkg::*;
#(
  parameter int unsigned HALT_UNIT = HALT_UNIT_CYC,
  parameter int unsigned SDZ_UNIT = SDZ_UNIT_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic shutdownNPin,
  input wire amc_cfg_t cfg,
  input wire logic softResetWrite,
  input wire logic signalBelowThreshold,
  input wire amc_pwr_t pwr,
  input wire logic [7:0] volume,
  input wire logic clockError,
  input wire logic softResetBit,
  input wire logic registerDefaults,
  input wire logic interruptNOut,
  input wire logic interruptNOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  int lowCnt, errCnt;
  // Cycles with the shutdown pin low and with a live clock fault
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt <= 0;
      errCnt <= 0;
    end else begin
      lowCnt <= shutdownNPin ? 0 : lowCnt + 1;
      errCnt <= clockError ? errCnt + 1 : 0;
    end
  end
  property p_soft_reset;
    softResetWrite |=> softResetBit && registerDefaults ##1 !softResetBit;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset");
  property p_irq;
    clockError && $past(clockError) && !cfg.clockErrorMask
      && !$past(cfg.clockErrorMask) |-> interruptNOe && !interruptNOut;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not driven");
  property p_forced;
    $fell(shutdownNPin) && cfg.shutdownBehaviourSel == SDZ_FORCED
      ##1 !shutdownNPin [*6] |-> pwr.hwShutdown;
  endproperty
  a_forced: assert property (p_forced) else $error("forced shutdown");
  property p_bus;
    pwr.hwShutdown && $past(pwr.hwShutdown) |-> !pwr.busEnable
      && registerDefaults;
  endproperty
  a_bus: assert property (p_bus) else $error("bus live in shutdown");
  property p_timeout;
    lowCnt > (cfg.shutdownTimeoutSel + 1) * SDZ_UNIT + 4 |-> pwr.hwShutdown;
  endproperty
  a_timeout: assert property (p_timeout) else $error("no timeout");
  property p_ramp;
    $fell(pwr.outputSwitching) && shutdownNPin && !clockError
      && !signalBelowThreshold |-> volume == 8'h00;
  endproperty
  a_ramp: assert property (p_ramp) else $error("switching cut early");
  property p_mute;
    cfg.modeSel == MODE_MUTE && volume == 8'h00 && pwr.outputSwitching
      && !clockError && !signalBelowThreshold && shutdownNPin
      |=> pwr.outputSwitching;
  endproperty
  a_mute: assert property (p_mute) else $error("mute stopped output");
  property p_halt;
    $rose(pwr.haltActive) |-> !$past(cfg.haltDisable)
      && errCnt >= (cfg.haltTimerSel + 1) * HALT_UNIT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt too early");
endmodule
bind amc_mode_clock_monitor amc_mode_clock_monitor_sva #(
  .HALT_UNIT(HALT_UNIT), .SDZ_UNIT(SDZ_UNIT)
) amc_mode_clock_monitor_sva_i (
  .clock(clock), .sys_rst(sys_rst), .shutdownNPin(shutdownNPin), .cfg(cfg),
  .softResetWrite(softResetWrite), .pwr(pwr), .volume(volume),
  .signalBelowThreshold(signalBelowThreshold), .clockError(clockError),
  .softResetBit(softResetBit), .registerDefaults(registerDefaults),
  .interruptNOut(interruptNOut), .interruptNOe(interruptNOe)
);
`default_nettype wire

// file: amc_host_model.sv
// Host-side serial audio clock source
`timescale 1ns/1ps
`default_nettype none
module amc_host_model (
  input var logic run,
  input var int ratio,
  input var int halfPs,
  output logic serialBitClock,
  output logic frameSync
);
  int bitCnt;
  // Frame sync marks the first bit; both stand still while stopped
  initial begin
    serialBitClock = 1'b0;
    frameSync = 1'b0;
    forever begin
      if (!run) begin
        serialBitClock = 1'b0;
        frameSync = 1'b0;
        bitCnt = 0;
        wait (run);
      end
      frameSync = (bitCnt == 0);
      #(halfPs / 1000.0);
      serialBitClock = 1'b1;
      #(halfPs / 1000.0);
      serialBitClock = 1'b0;
      bitCnt = (bitCnt + 1) % ratio;
    end
  end
endmodule
`default_nettype wire

// file: amc_mode_clock_monitor_tb.sv
// Self-checking bench for the mode controller and clock monitor
`timescale 1ns/1ps
`default_nettype none
module amc_mode_clock_monitor_tb;
  import amc_pkg::*;
  logic clock, sys_rst, shutdownNPin, addrStrapPin, run, softResetWrite;
  logic clearLatched, signalBelowThreshold, serialBitClock, frameSync;
  logic clockError, clockErrorLatched, softResetBit, registerDefaults;
  logic busAddress, interruptNOut, interruptNOe, echoTxBit, echoTxOe;
  logic diagOscEn;
  logic [7:0] volume;
  logic [31:0] playbackSample, diagSample;
  logic [5:0] mon;
  amc_cfg_t cfg;
  amc_pwr_t pwr;
  int ratio, halfPs, n_mismatch, compares;
  // Flags watched by the bounded waits
  assign mon = {echoTxOe, pwr.busEnable, pwr.haltActive, pwr.hwShutdown,
    pwr.outputSwitching, clockError};
  ////////////////////////////////////////////////////////////////////////////
  // Host clock source and block under test
  amc_host_model amc_host_model_i (.run(run), .ratio(ratio), .halfPs(halfPs),
    .serialBitClock(serialBitClock), .frameSync(frameSync));
  amc_mode_clock_monitor #(.HALT_UNIT(50), .SDZ_UNIT(400))
  amc_mode_clock_monitor_i (.clock(clock), .sys_rst(sys_rst), .clkEn(1'b1),
    .serialBitClock(serialBitClock), .frameSync(frameSync), .cfg(cfg),
    .shutdownNPin(shutdownNPin), .addrStrapPin(addrStrapPin),
    .softResetWrite(softResetWrite), .clearLatched(clearLatched),
    .signalBelowThreshold(signalBelowThreshold), .pwr(pwr),
    .playbackSample(playbackSample), .volume(volume),
    .clockError(clockError), .clockErrorLatched(clockErrorLatched),
    .softResetBit(softResetBit), .registerDefaults(registerDefaults),
    .busAddress(busAddress), .interruptNOut(interruptNOut),
    .interruptNOe(interruptNOe), .echoTxBit(echoTxBit),
    .echoTxOe(echoTxOe), .diagOscEn(diagOscEn), .diagSample(diagSample));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, bounded wait and closing report
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] probe(input int w);
    return (w == 6) ? volume : {7'h00, mon[w]};
  endfunction
  task automatic wt(input int w, input logic [7:0] v, input int n,
    input string what);
    int i;
    @(negedge clock);
    for (i = 0; i < n && probe(w) !== v; i++) begin
      @(negedge clock);
    end
    chk(what, 32'(v), 32'(probe(w)));
    if (probe(w) !== v) begin
      report_and_stop();
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_active;
    wt(6, 8'h08, 3000, "volume up");
    wt(0, 8'h00, 1, "clock error");
    wt(1, 8'h01, 1, "switching");
    chk("sense", 32'h1, 32'(pwr.senseEnable));
    wt(5, 8'h00, 2000, "echo idle");
    wt(5, 8'h01, 2000, "echo slot");
    chk("echo msb", 32'h1, 32'(echoTxBit));
    @(posedge clock);
    cfg.noiseGateEn <= 1'b1;
    signalBelowThreshold <= 1'b1;
    wt(1, 8'h00, 4, "gate closed");
    @(posedge clock);
    signalBelowThreshold <= 1'b0;
    wt(1, 8'h01, 400, "gate open");
    $display("active test done");
  endtask
  task automatic t_modes;
    @(posedge clock);
    cfg.modeSel <= MODE_MUTE;
    wt(6, 8'h00, 2000, "mute volume");
    wt(1, 8'h01, 1, "mute switching");
    @(posedge clock);
    cfg.modeSel <= MODE_ACTIVE;
    wt(6, 8'h08, 2000, "unmute volume");
    @(posedge clock);
    cfg.modeSel <= MODE_SW_SHUTDOWN;
    wt(1, 8'h00, 2000, "sw shutdown");
    chk("sd volume", 32'h0, 32'(volume));
    @(posedge clock);
    cfg.modeSel <= MODE_ACTIVE;
    wt(1, 8'h01, 10, "restart");
    wt(6, 8'h08, 2000, "ramp back");
    $display("mode test done");
  endtask
  task automatic t_soft_diag;
    @(posedge clock);
    softResetWrite <= 1'b1;
    @(posedge clock);
    softResetWrite <= 1'b0;
    @(negedge clock);
    chk("reset bit", 32'h1, 32'(softResetBit));
    chk("defaults", 32'h1, 32'(registerDefaults));
    @(negedge clock);
    chk("reset clear", 32'h0, 32'(softResetBit));
    @(posedge clock);
    cfg.playbackDcBlockSel <= 3'h0;
    cfg.diagEnable <= 1'b1;
    cfg.diagPatternSel <= DIAG_PAT_DC;
    cfg.diagDcLevel <= 32'h1234abcd;
    repeat (2) @(negedge clock);
    chk("osc", 32'h1, 32'(diagOscEn));
    chk("dc level", 32'h1234abcd, diagSample);
    cfg.diagClockSel <= 1'b1;
    @(negedge clock);
    chk("osc off", 32'h0, 32'(diagOscEn));
    cfg.diagEnable <= 1'b0;
    $display("reset and diag test done");
  endtask
  task automatic t_fault;
    @(posedge clock);
    cfg.autoPowerCycleEn <= 1'b1; // rate stays fixed from here
    ratio <= 100;
    halfPs <= 100000;
    run <= 1'b1;
    wt(0, 8'h01, 4000, "bad ratio");
    wt(6, 8'h00, 2000, "fault ramp");
    chk("irq", 32'h1, 32'(interruptNOe));
    chk("latched", 32'h1, 32'(clockErrorLatched));
    wt(3, 8'h01, 3000, "halt");
    run <= 1'b0;
    @(posedge clock);
    ratio <= 96;
    halfPs <= 108507;
    run <= 1'b1;
    wt(0, 8'h00, 5000, "fault gone");
    wt(3, 8'h00, 100, "halt left");
    wt(6, 8'h08, 3000, "volume back");
    clearLatched <= 1'b1;
    @(posedge clock);
    clearLatched <= 1'b0;
    @(negedge clock);
    chk("latch clear", 32'h0, 32'(clockErrorLatched));
    $display("clock fault test done");
  endtask
  task automatic t_shutdown;
    @(posedge clock);
    shutdownNPin <= 1'b0;
    wt(1, 8'h00, 600, "graceful stop");
    chk("sdz volume", 32'h0, 32'(volume));
    chk("analog on", 32'h1, 32'(pwr.analogPowered));
    @(negedge clock);
    chk("analog off", 32'h0, 32'(pwr.analogPowered));
    wt(2, 8'h01, 3, "hw shutdown");
    chk("bus off", 32'h0, 32'(pwr.busEnable));
    addrStrapPin <= 1'b0;
    shutdownNPin <= 1'b1;
    wt(4, 8'h01, 10, "release");
    chk("address", 32'h0, 32'(busAddress));
    cfg.shutdownBehaviourSel <= SDZ_FORCED;
    wt(6, 8'h08, 3000, "replay");
    shutdownNPin <= 1'b0;
    wt(2, 8'h01, 8, "forced");
    chk("forced defaults", 32'h1, 32'(registerDefaults));
    repeat (420) @(posedge clock);
    shutdownNPin <= 1'b1;
    $display("shutdown test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    sys_rst = 1'b1;
    {shutdownNPin, addrStrapPin, run} = 3'h7;
    {softResetWrite, clearLatched, signalBelowThreshold} = 3'h0;
    cfg = '0; // Rate is set before any diagnostic pattern
    cfg.volumeLevel = 8'h08;
    cfg.haltTimerSel = 3'h1;
    cfg.echoTxEn = 1'b1;
    playbackSample = 32'ha5a50000;
    ratio = 96;
    halfPs = 108507;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    wt(4, 8'h01, 20, "bus up");
    chk("strap", 32'h1, 32'(busAddress));
    t_active();
    t_modes();
    t_soft_diag();
    t_fault();
    t_shutdown();
    report_and_stop();
  end
endmodule
`default_nettype wire
